// ===== dv/bce_top_properties.sv
`include "bce_map.vh"

// ****
// checker on the top ports
// ****
module bce_top_properties (
    // clock, reset, enable
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // register port
    input wire [15:0] addr_in,
    input wire [15:0] wr_data_in,
    input wire wr_in,
    input wire rd_in,
    input wire [15:0] rd_data_out,
    input wire rd_valid_out,
    // detectors and events
    input wire [15:0] overcurrent_in,
    input wire [15:0] undervolt_in,
    input wire [15:0] timer_expired_in,
    input wire global_timeout_in,
    input wire global_undervolt_in,
    // balancing controls
    input wire [15:0] balance_on_out,
    input wire [15:0] timer_run_out,
    input wire global_balance_enable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // a strobe the port accepts
    sequence rd_req;
        rd_in && ce_in;
    endsequence
    // a zero written to the channel enables
    sequence zero_wr;
        wr_in && ce_in && addr_in == `BCE_ADDR_CH_EN && wr_data_in == 16'h0000;
    endsequence

    rd_valid_a: assert property (rd_req |=> rd_valid_out)
        else $error("read not answered");
    rd_idle_a: assert property (ce_in && !rd_in |=> !rd_valid_out && rd_data_out == 16'h0000)
        else $error("read port not idle");
    timer_same_a: assert property (balance_on_out == timer_run_out)
        else $error("timer runs while off");
    global_gate_a: assert property (balance_on_out != 16'h0000 |-> global_balance_enable_out)
        else $error("balancing without global");
    zero_write_a: assert property (zero_wr |=> ##1 balance_on_out == 16'h0000)
        else $error("zero write left balancing");
    // four sampled edges of a held fault are exactly what the two sync stages, the clear and the output register need
    oc_stop_a: assert property (($past(overcurrent_in) & $past(overcurrent_in, 2)
        & $past(overcurrent_in, 3) & $past(overcurrent_in, 4) & balance_on_out) == 16'h0000)
        else $error("overcurrent did not stop");
    tmr_stop_a: assert property (($past(timer_expired_in, 2) & balance_on_out) == 16'h0000)
        else $error("timer expiry did not stop");
    glob_stop_a: assert property (global_timeout_in [*4] |=> !global_balance_enable_out)
        else $error("global timeout did not stop");
endmodule

bind bce_top bce_top_properties i_bce_top_properties (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .overcurrent_in(overcurrent_in),
    .undervolt_in(undervolt_in), .timer_expired_in(timer_expired_in),
    .global_timeout_in(global_timeout_in), .global_undervolt_in(global_undervolt_in),
    .balance_on_out(balance_on_out), .timer_run_out(timer_run_out),
    .global_balance_enable_out(global_balance_enable_out));

// ===== dv/tb_top.sv
`include "bce_map.vh"

// ****
// register and detector bench
// ****
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, rst_in = 1, ce_in = 1, wr_in = 0, rd_in = 0, gto = 0, guv = 0;
    logic [15:0] addr = 0, wdat = 0, oc = 0, uv = 0, tmr = 0, rdat, bon, trun;
    logic rval, gbe;
    int fails = 0, tests_run = 0, cyc = 0;

    bce_top i_bce_top (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr),
        .wr_data_in(wdat), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rdat),
        .rd_valid_out(rval), .overcurrent_in(oc), .undervolt_in(uv), .timer_expired_in(tmr),
        .global_timeout_in(gto), .global_undervolt_in(guv), .balance_on_out(bon),
        .timer_run_out(trun), .global_balance_enable_out(gbe));

    // 125 MHz clock
    always #4 clk_in = ~clk_in;

    task test_done();
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask

    // strobes start after a rising edge, so back-to-back calls never collide
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr <= a;
        wdat <= d;
        wr_in <= 1;
        @(posedge clk_in);
        wr_in <= 0;
    endtask

    // data are looked at mid-cycle after the taking edge, their only cycle
    task rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk_in);
        addr <= a;
        rd_in <= 1;
        @(posedge clk_in);
        rd_in <= 0;
        @(negedge clk_in);
        chk(rdat, e);
        chk({15'h0000, rval}, 16'h0001);
    endtask

    task idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // hang guard, the sequence needs under a hundred cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            test_done();
        end
    end

    // main sequence
    initial begin
        idle(4);
        rst_in <= 0;
        rd(`BCE_ADDR_CH_EN, 16'h0000);
        wr(`BCE_ADDR_CH_EN, 16'hffff);
        rd(`BCE_ADDR_CH_EN, 16'hffff);
        chk(bon, 16'h0000);
        wr(`BCE_ADDR_GLOB_CFG, 16'h0001);
        wr(`BCE_ADDR_CH_EN, 16'h5a5a);
        wr(16'h1003, 16'h0000);
        rd(16'h1001, 16'h0000);
        chk(bon, 16'h5a5a);
        chk(trun, 16'h5a5a);
        wr(`BCE_ADDR_CH_EN, 16'h0000);
        rd(`BCE_ADDR_CH_EN, 16'h0000);
        wr(`BCE_ADDR_CH_EN, 16'hffff);
        oc <= 16'h0008;
        idle(5);
        wr(`BCE_ADDR_CH_EN, 16'hffff);
        rd(`BCE_ADDR_CH_EN, 16'hfff7);
        rd(`BCE_ADDR_OC_CAUSE, 16'h0008);
        oc <= 16'h0000;
        uv <= 16'h0020;
        idle(5);
        rd(`BCE_ADDR_CH_EN, 16'hfff7);
        wr(`BCE_ADDR_GLOB_CFG, 16'h0005);
        idle(3);
        rd(`BCE_ADDR_CH_EN, 16'hffd7);
        uv <= 16'h0000;
        idle(4);
        tmr <= 16'h0001;
        wr(`BCE_ADDR_CH_EN, 16'hffff);
        tmr <= 16'h0000;
        rd(`BCE_ADDR_CH_EN, 16'hfffe);
        chk(bon, 16'hfffe);
        rd(`BCE_ADDR_STATUS, 16'hfffe);
        idle(1);
        gto <= 1;
        idle(6);
        gto <= 0;
        rd(`BCE_ADDR_GLOB_CFG, 16'h0004);
        chk(trun, 16'h0000);
        rd(`BCE_ADDR_CH_EN, 16'hfffe);
        wr(`BCE_ADDR_GLOB_CFG, 16'h0009);
        rd(`BCE_ADDR_GLOB_CFG, 16'h0009);
        chk({15'h0000, gbe}, 16'h0001);
        idle(1);
        guv <= 1;
        idle(6);
        guv <= 0;
        rd(`BCE_ADDR_GLOB_CFG, 16'h0008);
        chk({15'h0000, gbe}, 16'h0000);
        test_done();
    end
endmodule

// ===== rtl/bce_chan.v
`include "bce_map.vh"

// ****************************************
// one channel enable bit with sticky cause flags
// ****************************************
module bce_chan (
    // clock, reset, enable
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // software write to the enable bit
    input wire wr_in,
    input wire wr_val_in,
    // hardware clear requests, already qualified
    input wire oc_in,
    input wire uv_in,
    input wire tmr_in,
    // write-one-to-clear strobes for the cause flags
    input wire [2:0] cause_clr_in,
    // state
    output reg en_out,
    output reg [2:0] cause_out
);

    wire hw_clr;
    wire [2:0] cause_set;

    assign hw_clr = oc_in | uv_in | tmr_in;
    assign cause_set = {tmr_in, uv_in, oc_in};

    // hardware clear beats a software write in the same cycle
    always @(posedge clk_in) begin
        if (rst_in) begin
            en_out <= 1'b0;
        end else if (ce_in) begin
            if (hw_clr) begin
                en_out <= 1'b0;
            end else if (wr_in) begin
                en_out <= wr_val_in;
            end
        end
    end

    // a new cause wins over a clear arriving together with it
    always @(posedge clk_in) begin
        if (rst_in) begin
            cause_out <= 3'b000;
        end else if (ce_in) begin
            cause_out <= (cause_out & ~cause_clr_in) | cause_set;
        end
    end

endmodule

// ===== rtl/bce_map.vh
`ifndef BCE_MAP_VH
`define BCE_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define BCE_ADDR_GLOB_CFG 16'h1000
`define BCE_ADDR_CH_EN 16'h1002
`define BCE_ADDR_OC_CAUSE 16'h10f0
`define BCE_ADDR_UV_CAUSE 16'h10f1
`define BCE_ADDR_TMR_CAUSE 16'h10f2
`define BCE_ADDR_STATUS 16'h10f3

// ****************************************
// field positions
// ****************************************
`define BCE_GLOB_EN_BIT 0
`define BCE_CHUV_STOP_BIT 2
`define BCE_GLOBUV_STOP_BIT 3
`define BCE_CAUSE_OC_BIT 0
`define BCE_CAUSE_UV_BIT 1
`define BCE_CAUSE_TMR_BIT 2

// ****************************************
// reset values and widths
// ****************************************
`define BCE_CH_EN_RST 16'h0000
`define BCE_GLOB_CFG_RST 16'h0000
`define BCE_GLOB_EN_RST 1'b0
`define BCE_RD_IDLE 16'h0000
`define BCE_NUM_CH 16

`endif

// ===== rtl/bce_sync2.v
// ****************************************
// two-stage level synchroniser
// ****************************************
module bce_sync2 #(
    parameter W = 16
) (
    // clock, reset, enable
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // asynchronous levels in, synchronised levels out
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);

    reg [W-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge clk_in) begin
        if (rst_in) begin
            meta <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end else if (ce_in) begin
            meta <= d_in;
            q_out <= meta;
        end
    end

endmodule

// ===== rtl/bce_top.v
`include "bce_map.vh"

// ****************************************
// Summary of operation
// - a 16-bit register at address 1002h holds one enable bit per channel, bit n for channel n.
// - software reads and writes every channel enable bit, and each resets to zero.
// - a channel whose enable bit is one is treated as balancing enabled.
// - a channel whose enable bit is zero has balancing off and its timer held stopped.
// - an over-current on a channel clears that channel's enable bit.
// - an under-voltage on a channel clears its enable bit only when that stop is enabled.
// - expiry of a channel's own timer clears that channel's enable bit.
// - global enable gates all balancing and timers; timeout or enabled global uv clears it.
// - the per-channel under-voltage stop acts only while its global configuration bit is one.
// ****************************************
module bce_top (
    // clock, reset, enable
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // register port
    input wire [15:0] addr_in,
    input wire [15:0] wr_data_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rd_data_out,
    output reg rd_valid_out,
    // per-channel detectors, asynchronous comparator levels
    input wire [15:0] overcurrent_in,
    input wire [15:0] undervolt_in,
    // per-channel timer expiry, same clock
    input wire [15:0] timer_expired_in,
    // global events
    input wire global_timeout_in,
    input wire global_undervolt_in,
    // balancing controls
    output reg [15:0] balance_on_out,
    output reg [15:0] timer_run_out,
    output reg global_balance_enable_out
);

    // ****************************************
    // declarations
    // ****************************************
    wire [15:0] oc_sync;
    wire [15:0] uv_sync;
    wire [1:0] glob_sync;
    wire glob_timeout;
    wire glob_uv;
    wire [15:0] ch_en;
    wire [15:0] oc_cause;
    wire [15:0] uv_cause;
    wire [15:0] tmr_cause;
    wire [15:0] oc_clr;
    wire [15:0] uv_clr;
    wire [15:0] tmr_clr;
    wire [15:0] next_balance_on;
    wire sel_glob;
    wire sel_ch;
    wire sel_oc;
    wire sel_uv;
    wire sel_tmr;
    wire sel_stat;
    wire wr_glob;
    wire wr_ch;
    wire wr_oc;
    wire wr_uv;
    wire wr_tmr;
    wire glob_hw_clr;
    wire next_glob_en;
    reg global_balance_enable;
    reg channel_undervolt_stop_enable;
    reg global_undervolt_stop_enable;
    reg [15:0] next_rd_data;

    // ****************************************
    // input synchronisation
    // ****************************************

    // comparators are not on this clock, so two stages before use
    bce_sync2 #(
        .W(16)
    ) u_sync_oc (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .d_in(overcurrent_in),
        .q_out(oc_sync)
    );

    bce_sync2 #(
        .W(16)
    ) u_sync_uv (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .d_in(undervolt_in),
        .q_out(uv_sync)
    );

    // global under-voltage also comes from a comparator
    bce_sync2 #(
        .W(2)
    ) u_sync_glob (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .d_in({global_undervolt_in, global_timeout_in}),
        .q_out(glob_sync)
    );

    assign glob_timeout = glob_sync[0];
    assign glob_uv = glob_sync[1];

    // ****************************************
    // address decode
    // ****************************************

    // full 16-bit compare, no aliasing
    assign sel_glob = (addr_in == `BCE_ADDR_GLOB_CFG);
    assign sel_ch = (addr_in == `BCE_ADDR_CH_EN);
    assign sel_oc = (addr_in == `BCE_ADDR_OC_CAUSE);
    assign sel_uv = (addr_in == `BCE_ADDR_UV_CAUSE);
    assign sel_tmr = (addr_in == `BCE_ADDR_TMR_CAUSE);
    assign sel_stat = (addr_in == `BCE_ADDR_STATUS);

    assign wr_glob = wr_in & sel_glob;
    assign wr_ch = wr_in & sel_ch;
    assign wr_oc = wr_in & sel_oc;
    assign wr_uv = wr_in & sel_uv;
    assign wr_tmr = wr_in & sel_tmr;

    // cause flags clear where a one is written
    assign oc_clr = wr_oc ? wr_data_in : 16'h0000;
    assign uv_clr = wr_uv ? wr_data_in : 16'h0000;
    assign tmr_clr = wr_tmr ? wr_data_in : 16'h0000;

    // ****************************************
    // global configuration
    // ****************************************

    // global bit falls on timeout or on an enabled global under-voltage
    assign glob_hw_clr = glob_timeout | (glob_uv & global_undervolt_stop_enable);

    // hardware clear wins over a write setting the bit
    assign next_glob_en = glob_hw_clr ? 1'b0 :
        (wr_glob ? wr_data_in[`BCE_GLOB_EN_BIT] : global_balance_enable);

    always @(posedge clk_in) begin
        if (rst_in) begin
            global_balance_enable <= `BCE_GLOB_EN_RST;
            channel_undervolt_stop_enable <= 1'b0;
            global_undervolt_stop_enable <= 1'b0;
        end else if (ce_in) begin
            global_balance_enable <= next_glob_en;
            if (wr_glob) begin
                channel_undervolt_stop_enable <= wr_data_in[`BCE_CHUV_STOP_BIT];
                global_undervolt_stop_enable <= wr_data_in[`BCE_GLOBUV_STOP_BIT];
            end
        end
    end

    // ****************************************
    // channel enable bits
    // ****************************************

    // one cell per channel; clears are qualified here, priority lives in the cell
    genvar gi;
    generate
        for (gi = 0; gi < `BCE_NUM_CH; gi = gi + 1) begin : g_ch
            bce_chan u_chan (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .ce_in(ce_in),
                .wr_in(wr_ch),
                .wr_val_in(wr_data_in[gi]),
                .oc_in(oc_sync[gi]),
                .uv_in(uv_sync[gi] & channel_undervolt_stop_enable),
                .tmr_in(timer_expired_in[gi]),
                .cause_clr_in({tmr_clr[gi], uv_clr[gi], oc_clr[gi]}),
                .en_out(ch_en[gi]),
                .cause_out({tmr_cause[gi], uv_cause[gi], oc_cause[gi]})
            );
        end
    endgenerate

    // ****************************************
    // balancing outputs
    // ****************************************

    // a channel balances only with its own bit and the global bit both set
    assign next_balance_on = ch_en & {16{global_balance_enable}};

    // outputs lag the enable state by one registered cycle
    always @(posedge clk_in) begin
        if (rst_in) begin
            balance_on_out <= 16'h0000;
            timer_run_out <= 16'h0000;
            global_balance_enable_out <= 1'b0;
        end else if (ce_in) begin
            balance_on_out <= next_balance_on;
            timer_run_out <= next_balance_on;
            global_balance_enable_out <= global_balance_enable;
        end
    end

    // ****************************************
    // read path
    // ****************************************

    // unmapped addresses and reserved bits read as zero
    always @* begin
        next_rd_data = `BCE_RD_IDLE;
        if (rd_in) begin
            if (sel_glob) begin
                next_rd_data[`BCE_GLOB_EN_BIT] = global_balance_enable;
                next_rd_data[`BCE_CHUV_STOP_BIT] = channel_undervolt_stop_enable;
                next_rd_data[`BCE_GLOBUV_STOP_BIT] = global_undervolt_stop_enable;
            end else if (sel_ch) begin
                next_rd_data = ch_en;
            end else if (sel_oc) begin
                next_rd_data = oc_cause;
            end else if (sel_uv) begin
                next_rd_data = uv_cause;
            end else if (sel_tmr) begin
                next_rd_data = tmr_cause;
            end else if (sel_stat) begin
                next_rd_data = next_balance_on;
            end
        end
    end

    // data stands only in the cycle after the strobe
    always @(posedge clk_in) begin
        if (rst_in) begin
            rd_data_out <= `BCE_RD_IDLE;
            rd_valid_out <= 1'b0;
        end else if (ce_in) begin
            rd_data_out <= next_rd_data;
            rd_valid_out <= rd_in;
        end
    end

endmodule
